// ---- src/wwdt_pkg.sv ----
package wwdt_pkg;
   // ****************************************
   // counter and prescaler
   // ****************************************
   localparam int WWDT_CNT_W = 12;
   localparam int WWDT_PRESC_DIV = 128;
   localparam int WWDT_PRESC_W = 7;
   localparam logic [6:0] WWDT_PRESC_LAST = 7'(WWDT_PRESC_DIV - 1);
   localparam logic [6:0] WWDT_PRESC_RST = 7'h00;
   localparam logic [11:0] WWDT_RELOAD_RST = 12'hFFF;
   localparam logic [11:0] WWDT_WINDOW_RST = 12'hFFF;
   localparam logic [11:0] WWDT_CNT_ZERO = 12'h000;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] WWDT_OFS_MODE = 8'h00;
   localparam logic [7:0] WWDT_OFS_CTRL = 8'h04;
   localparam logic [7:0] WWDT_OFS_FLAG = 8'h08;
   localparam logic [7:0] WWDT_OFS_CLR = 8'h0C;
   localparam logic [7:0] WWDT_OFS_IEN = 8'h10;
   localparam logic [7:0] WWDT_OFS_CNT = 8'h14;

   // control word: key in the top byte, restart in bit 0
   localparam int WWDT_KEY_LSB = 24;
   localparam int WWDT_RESTART_BIT = 0;
   // key value is arbitrary
   localparam logic [7:0] WWDT_KEY = 8'hA5;

   localparam int WWDT_MODE_W = 29;
   localparam int WWDT_FLAG_W = 2;
   localparam logic [1:0] WWDT_FLAGS_RST = 2'h0;
   localparam logic [1:0] WWDT_IEN_RST = 2'h0;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic idle_halt;
      logic debug_halt;
      logic [11:0] restart_window_limit;
      logic disable_bit;
      logic fault_reset_enable;
      logic fault_interrupt_enable;
      logic [11:0] timeout_reload_value;
   } wwdt_mode_t;

   localparam wwdt_mode_t WWDT_MODE_RST = '{
      idle_halt: 1'b0, debug_halt: 1'b0, restart_window_limit: WWDT_WINDOW_RST,
      disable_bit: 1'b0, fault_reset_enable: 1'b1, fault_interrupt_enable: 1'b0,
      timeout_reload_value: WWDT_RELOAD_RST};

   typedef struct packed {
      logic restart_error_flag;
      logic underflow_flag;
   } wwdt_flags_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } wwdt_bus_req_t;
endpackage

// ---- src/wwdt_top.sv ----
`timescale 1ns/1ps
// How it works
// - twelve-bit down counter loaded from reload value
// - counter steps once per 128 slow clocks
// - reset gives reload FFF, fault reset enabled
// - disable bit stops the counter
// - mode setting accepts only first write
// - mode write reloads and restarts counter
// - valid restart reloads counter and clears prescaler
// - control write without key does nothing
// - underflow sets flag, fault if enabled
// - restart outside window flags error, asserts fault
// - window at or above reload disables check
// - flags interrupt only with interrupt enable set
// - watchdog reset clears both flags
// - flag read or reset clears flags, fault
// - idle or debug halts counter when selected
module wwdt_top
   import wwdt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wwdt_bus_req_t bus_req,
   output logic [31:0] rdata_q,
   input wire logic slow_clk,
   input wire logic cpu_idle,
   input wire logic cpu_debug,
   output logic fault_q,
   output logic irq_q
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic key_ok(input logic [31:0] w);
      return w[WWDT_KEY_LSB +: 8] == WWDT_KEY;
   endfunction

   // a restart is an error only strictly between window limit and reload
   function automatic logic out_of_window(input logic [11:0] c, input wwdt_mode_t m);
      return (c > m.restart_window_limit) && (c < m.timeout_reload_value);
   endfunction

   function automatic logic hit(input wwdt_bus_req_t r, input logic [7:0] ofs);
      return r.addr == ofs;
   endfunction

   // ****************************************
   // state
   // ****************************************
   wwdt_mode_t mode_q;
   logic mode_locked_q;
   logic [11:0] cnt_q;
   logic [6:0] presc_q;
   logic slow_q;
   wwdt_flags_t flags_q;
   logic [1:0] ien_q;

   logic mode_wr;
   logic ctrl_wr;
   logic restart_req;
   logic win_err;
   logic reload;
   logic run;
   logic slow_rise;
   logic tick;
   logic unf_ev;
   logic flag_rd;
   logic [1:0] clr_bits;
   wwdt_mode_t new_mode;

   assign new_mode = wwdt_mode_t'(bus_req.wdata[WWDT_MODE_W-1:0]);
   assign mode_wr = bus_req.wr && hit(bus_req, WWDT_OFS_MODE) && !mode_locked_q;
   assign ctrl_wr = bus_req.wr && hit(bus_req, WWDT_OFS_CTRL);
   assign restart_req = ctrl_wr && key_ok(bus_req.wdata)
      && bus_req.wdata[WWDT_RESTART_BIT];
   // checked even while disabled; a wide window never errors
   assign win_err = restart_req && out_of_window(cnt_q, mode_q);
   assign reload = mode_wr || (restart_req && !win_err);
   assign run = !mode_q.disable_bit
      && !(cpu_idle && mode_q.idle_halt)
      && !(cpu_debug && mode_q.debug_halt);
   assign slow_rise = slow_clk && !slow_q;
   assign tick = run && slow_rise && (presc_q == WWDT_PRESC_LAST);
   assign unf_ev = tick && (cnt_q == WWDT_CNT_ZERO);
   assign flag_rd = bus_req.rd && hit(bus_req, WWDT_OFS_FLAG);
   assign clr_bits = (bus_req.wr && hit(bus_req, WWDT_OFS_CLR)) ?
      bus_req.wdata[WWDT_FLAG_W-1:0] : 2'h0;

   // ****************************************
   // mode setting, write once
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mode_q <= WWDT_MODE_RST;
         mode_locked_q <= 1'b0;
      end else if (mode_wr) begin
         mode_q <= new_mode;
         mode_locked_q <= 1'b1;
      end
   end

   // ****************************************
   // slow clock prescaler
   // ****************************************
   // slow_clk is taken as synchronous to clock, so only an edge detect is needed
   always_ff @(posedge clock) begin
      if (!nrst) begin
         slow_q <= 1'b0;
      end else begin
         slow_q <= slow_clk;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         presc_q <= WWDT_PRESC_RST;
      end else if (reload) begin
         presc_q <= WWDT_PRESC_RST;
      end else if (run && slow_rise) begin
         presc_q <= 7'(presc_q + 7'h01);
      end
   end

   // ****************************************
   // down counter
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_q <= WWDT_RELOAD_RST;
      end else if (mode_wr) begin
         cnt_q <= new_mode.timeout_reload_value;
      end else if (reload) begin
         cnt_q <= mode_q.timeout_reload_value;
      end else if (tick) begin
         // keeps running after underflow so a disabled fault still repeats the flag
         cnt_q <= (cnt_q == WWDT_CNT_ZERO) ? mode_q.timeout_reload_value
            : 12'(cnt_q - 12'h001);
      end
   end

   // ****************************************
   // flags, fault and interrupt
   // ****************************************
   // a new event wins over a read or a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         flags_q <= WWDT_FLAGS_RST;
      end else begin
         flags_q.underflow_flag <= unf_ev
            || (flags_q.underflow_flag && !flag_rd && !clr_bits[0]);
         flags_q.restart_error_flag <= win_err
            || (flags_q.restart_error_flag && !flag_rd && !clr_bits[1]);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= (unf_ev && mode_q.fault_reset_enable) || win_err
            || (fault_q && !flag_rd);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ien_q <= WWDT_IEN_RST;
      end else if (bus_req.wr && hit(bus_req, WWDT_OFS_IEN)) begin
         ien_q <= bus_req.wdata[WWDT_FLAG_W-1:0];
      end
   end

   // one cycle behind the flags, which keeps the output a plain flop
   always_ff @(posedge clock) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= mode_q.fault_interrupt_enable && |(flags_q & ien_q);
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            WWDT_OFS_MODE: rdata_q <= {3'h0, mode_q};
            WWDT_OFS_FLAG: rdata_q <= {30'h0, flags_q};
            WWDT_OFS_IEN: rdata_q <= {30'h0, ien_q};
            WWDT_OFS_CNT: rdata_q <= {20'h0, cnt_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   reload_restart_a: assert property (
      restart_req && !win_err |=> cnt_q == $past(mode_q.timeout_reload_value)
         && presc_q == WWDT_PRESC_RST)
      else $error("valid restart did not reload counter and prescaler");

   mode_reload_a: assert property (
      mode_wr |=> cnt_q == mode_q.timeout_reload_value && presc_q == WWDT_PRESC_RST)
      else $error("mode write did not reload counter");

   mode_lock_a: assert property (
      mode_locked_q |=> mode_q == $past(mode_q) && mode_locked_q)
      else $error("locked mode setting changed");

   key_check_a: assert property (
      ctrl_wr && !key_ok(bus_req.wdata) && !mode_wr && !tick |=> cnt_q == $past(cnt_q)
         && !$rose(flags_q.restart_error_flag))
      else $error("control write without key had an effect");

   disable_hold_a: assert property (
      mode_q.disable_bit && !reload |=> cnt_q == $past(cnt_q))
      else $error("disabled counter moved");

   halt_hold_a: assert property (
      cpu_idle && mode_q.idle_halt && !reload |=> cnt_q == $past(cnt_q))
      else $error("counter moved while halted in idle");

   underflow_fault_a: assert property (
      unf_ev && mode_q.fault_reset_enable |=> fault_q && flags_q.underflow_flag
         && cnt_q == $past(mode_q.timeout_reload_value))
      else $error("underflow did not raise fault and flag");

   window_err_a: assert property (
      restart_req && (cnt_q > mode_q.restart_window_limit)
         && (cnt_q < mode_q.timeout_reload_value)
         |=> flags_q.restart_error_flag && fault_q && cnt_q == $past(cnt_q))
      else $error("restart outside window not flagged");

   wide_window_a: assert property (
      restart_req && mode_q.restart_window_limit >= mode_q.timeout_reload_value
         |=> !$rose(flags_q.restart_error_flag))
      else $error("error raised with window check disabled");

   irq_gate_a: assert property (
      irq_q |-> $past(mode_q.fault_interrupt_enable) && $past(|(flags_q & ien_q)))
      else $error("interrupt without enable or flag");

   read_clear_a: assert property (
      flag_rd && !unf_ev && !win_err |=> flags_q == WWDT_FLAGS_RST && !fault_q ##1 !irq_q)
      else $error("flag read did not clear flags, fault and interrupt");

   // the default disable would make this one vacuous, so it opts out
   reset_vals_a: assert property (@(posedge clock) disable iff (1'b0)
      !nrst |=> mode_q == WWDT_MODE_RST && flags_q == WWDT_FLAGS_RST && !fault_q
         && cnt_q == WWDT_RELOAD_RST)
      else $error("reset values wrong");

   count_step_a: assert property (
      tick && cnt_q != WWDT_CNT_ZERO && !reload |=> cnt_q == $past(cnt_q) - 12'h001)
      else $error("counter did not step down by one on a tick");

   presc_hold_a: assert property (
      !run && !reload |=> presc_q == $past(presc_q))
      else $error("prescaler moved while the counter was stopped");

   underflow_flag_a: assert property (
      unf_ev |=> flags_q.underflow_flag)
      else $error("underflow did not set its flag");

   no_fault_a: assert property (
      unf_ev && !mode_q.fault_reset_enable && !win_err && !fault_q |=> !fault_q)
      else $error("fault raised by underflow with fault reset off");

   debug_hold_a: assert property (
      cpu_debug && mode_q.debug_halt && !reload |=> $stable(cnt_q))
      else $error("counter moved while halted in debug");

   clear_reg_a: assert property (
      clr_bits[0] && !unf_ev |=> !flags_q.underflow_flag)
      else $error("flag clear register did not clear underflow");

   irq_set_a: assert property (
      mode_q.fault_interrupt_enable && |(flags_q & ien_q) |=> irq_q)
      else $error("enabled flag did not raise the interrupt");

   lock_set_a: assert property (
      mode_wr |=> mode_locked_q && mode_q == $past(new_mode))
      else $error("first mode write not taken or not locked");

   fault_hold_a: assert property (
      fault_q && !flag_rd |=> fault_q)
      else $error("fault dropped without a flag read");

   rdata_idle_a: assert property (
      !bus_req.rd |=> rdata_q == 32'h0000_0000)
      else $error("read data not zero outside a read");

   underflow_c: cover property (unf_ev ##1 fault_q);
   window_err_c: cover property (win_err ##1 flags_q.restart_error_flag);
   restart_ok_c: cover property (restart_req && !win_err && cnt_q != WWDT_CNT_ZERO);
   irq_c: cover property (irq_q ##[1:3] flag_rd);
   halt_c: cover property (cpu_debug && mode_q.debug_halt && slow_rise);

endmodule // wwdt_top

// ---- bench/wwdt_rstc_model.sv ----
`timescale 1ns/1ps
// ****************************************
// reset controller stand-in
// ****************************************
module wwdt_rstc_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic fault,
   input wire logic arm,
   output logic rst_n
);
   logic [3:0] hold_q;
   // an armed fault becomes a ten-cycle reset, long enough to clear the block
   always_ff @(posedge clock) begin
      if (!nrst) begin
         hold_q <= 4'h0;
      end else if (fault && arm && hold_q == 4'h0) begin
         hold_q <= 4'hA;
      end else if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end
   end
   assign rst_n = (hold_q == 4'h0);
endmodule // wwdt_rstc_model

// ---- bench/tb_windowed_watchdog_timer.sv ----
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
   import wwdt_pkg::*;
   logic clock, nrst_b, model_n, slow_run, slow_clk, cpu_idle, cpu_debug, arm;
   logic nrst, fault_q, irq_q;
   logic [31:0] rdata_q, rv, m1;
   logic [11:0] rl;
   logic [7:0] k;
   wwdt_bus_req_t bus_req;
   int fails, checks_done, j;
   assign nrst = nrst_b & model_n;
   wwdt_top dut (.clock(clock), .nrst(nrst), .bus_req(bus_req), .rdata_q(rdata_q),
      .slow_clk(slow_clk), .cpu_idle(cpu_idle), .cpu_debug(cpu_debug),
      .fault_q(fault_q), .irq_q(irq_q));
   wwdt_rstc_model rstc (.clock(clock), .nrst(nrst_b), .fault(fault_q), .arm(arm),
      .rst_n(model_n));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // slow clock only toggles while a test lets it run
   always @(posedge clock) begin
      if (slow_run) slow_clk <= ~slow_clk;
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] mode_w(input logic [11:0] r, input logic fie, fre, dis,
      input logic [11:0] win, input logic dbg, idl);
      return {3'h0, idl, dbg, win, dis, fre, fie, r};
   endfunction
   function automatic logic [31:0] exp_cnt(input logic [11:0] r, input int edges);
      return {20'h0, r - 12'(edges / WWDT_PRESC_DIV)};
   endfunction
   task automatic results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge clock);
      bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 d = rdata_q;
   endtask
   task automatic rst_dut();
      @(posedge clock);
      nrst_b <= 1'b0;
      slow_run <= 1'b0;
      slow_clk <= 1'b0;
      cyc(10);
      nrst_b <= 1'b1;
      cyc(1);
   endtask
   task automatic run_slow(input int n);
      slow_run <= 1'b1;
      cyc(n);
      slow_run <= 1'b0;
   endtask
   task automatic wait_fault();
      for (int t = 0; t < 6000 && fault_q !== 1'b1; t++) cyc(1);
      if (fault_q !== 1'b1) begin
         fails++;
         results();
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      {nrst_b, slow_run, slow_clk, cpu_idle, cpu_debug, arm} = '0;
      bus_req = '0;
      void'($urandom(76459));
      rst_dut();
      rd(WWDT_OFS_CNT, rv); chk(rv, {20'h0, WWDT_RELOAD_RST});
      rd(WWDT_OFS_MODE, rv); chk(rv, 32'(WWDT_MODE_RST));
      rd(WWDT_OFS_FLAG, rv); chk(rv, 32'h0);
      rd(8'h40, rv); chk(rv, 32'h0);
      $display("test reset values done");
      rl = 12'(4 + $urandom % 8);
      m1 = mode_w(rl, 1'b1, 1'b1, 1'b0, 12'hFFF, 1'b0, 1'b0);
      wr(WWDT_OFS_MODE, m1);
      rd(WWDT_OFS_CNT, rv); chk(rv, {20'h0, rl});
      wr(WWDT_OFS_MODE, mode_w(12'h123, 1'b0, 1'b0, 1'b1, 12'h0, 1'b0, 1'b0));
      rd(WWDT_OFS_MODE, rv); chk(rv, m1);
      run_slow(400);
      rd(WWDT_OFS_CNT, rv); chk(rv, exp_cnt(rl, 200));
      k = 8'($urandom);
      if (k == WWDT_KEY) k = ~k;
      wr(WWDT_OFS_CTRL, {k, 24'h1});
      rd(WWDT_OFS_CNT, rv); chk(rv, exp_cnt(rl, 200));
      wr(WWDT_OFS_CTRL, {WWDT_KEY, 24'h1});
      rd(WWDT_OFS_CNT, rv); chk(rv, {20'h0, rl});
      rd(WWDT_OFS_FLAG, rv); chk(rv, 32'h0);
      // leftover prescaler phase would tick here if the restart had not cleared it
      run_slow(240);
      rd(WWDT_OFS_CNT, rv); chk(rv, {20'h0, rl});
      $display("test keyed restart done");
      wr(WWDT_OFS_IEN, 32'h3);
      slow_run <= 1'b1;
      wait_fault();
      cyc(1); chk({31'h0, irq_q}, 32'h1);
      rd(WWDT_OFS_FLAG, rv); chk(rv, 32'h1);
      chk({31'h0, fault_q}, 32'h0);
      cyc(1); chk({31'h0, irq_q}, 32'h0);
      arm <= 1'b1;
      wait_fault();
      cyc(14);
      arm <= 1'b0;
      slow_run <= 1'b0;
      rd(WWDT_OFS_FLAG, rv); chk(rv, 32'h0);
      rd(WWDT_OFS_CNT, rv); chk(rv, {20'h0, WWDT_RELOAD_RST});
      $display("test underflow done");
      rst_dut();
      wr(WWDT_OFS_MODE, mode_w(12'hA, 1'b1, 1'b0, 1'b0, 12'h3, 1'b0, 1'b0));
      run_slow(300);
      rd(WWDT_OFS_CNT, rv); chk(rv, exp_cnt(12'hA, 150));
      wr(WWDT_OFS_CTRL, {WWDT_KEY, 24'h1});
      chk({31'h0, fault_q}, 32'h1);
      chk({31'h0, irq_q}, 32'h0);
      rd(WWDT_OFS_CNT, rv); chk(rv, exp_cnt(12'hA, 150));
      wr(WWDT_OFS_IEN, 32'h2);
      cyc(2); chk({31'h0, irq_q}, 32'h1);
      wr(WWDT_OFS_CLR, 32'h2);
      cyc(2); chk({31'h0, irq_q}, 32'h0);
      rd(WWDT_OFS_FLAG, rv); chk(rv, 32'h0);
      $display("test window error done");
      for (j = 0; j < 3; j++) begin
         rst_dut();
         cpu_idle <= (j == 1);
         cpu_debug <= (j == 2);
         wr(WWDT_OFS_MODE, mode_w(12'h20, 1'b0, 1'b1, j == 0, 12'hFFF, 1'b1, 1'b1));
         run_slow(600);
         rd(WWDT_OFS_CNT, rv); chk(rv, 32'h20);
         cpu_idle <= 1'b0;
         cpu_debug <= 1'b0;
         run_slow(600);
         rd(WWDT_OFS_CNT, rv);
         if (j == 0) chk(rv, 32'h20);
         else chk({31'h0, rv == 32'h1E || rv == 32'h1D}, 32'h1);
      end
      $display("test halt and disable done");
      results();
   end
   initial begin
      #900000;
      fails++;
      results();
   end
endmodule // tb_windowed_watchdog_timer
